// [fdm_pkg.sv]
`default_nettype none
package fdm_pkg;
   // ******************************************
   // clock and timing
   // ******************************************
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned OSC_SW_US   = 500;
   localparam int unsigned OSC_SW_CYC  = OSC_SW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned LR_TMO_US   = 200;
   localparam int unsigned LR_TMO_CYC  = LR_TMO_US * (CLK_HZ / 1_000_000);
   localparam int unsigned NCH         = 4;
   // ******************************************
   // register map
   // ******************************************
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_CMD     = 8'h04;
   localparam logic [7:0] ADDR_CHAN    = 8'h08;
   localparam logic [7:0] ADDR_STAT    = 8'h0C;
   localparam logic [7:0] ADDR_ERR     = 8'h10;
   localparam logic [7:0] ADDR_VER     = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h1C;
   localparam int unsigned CTRL_AUDIO_OUTPUT_ENABLE  = 0;
   localparam int unsigned CTRL_AUDIO_INPUT_ENABLE   = 1;
   localparam int unsigned CTRL_FLTEN  = 2;
   localparam int unsigned CTRL_GRP    = 3;
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [15:0] CHAN_RST    = 16'h0000;
   localparam logic [5:0]  MASK_RST    = 6'h00;
   localparam int unsigned CH_HQ       = 2;
   localparam int unsigned CH_EN       = 3;
   localparam int unsigned ERR_OSC     = 0;
   localparam int unsigned ERR_MEM     = 1;
   localparam int unsigned ERR_LR      = 2;
   localparam int unsigned ERR_SDI     = 3;
   localparam int unsigned ERR_MIX     = 4;
   localparam int unsigned ERR_ALGO    = 5;
   localparam logic [7:0]  VER_ID      = 8'h5A; // arbitrary value
   localparam logic [1:0]  RESP_OK     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // channel limits per group while the serial audio input is enabled
   localparam logic [2:0]  MIX_LIM_8K  = 3'h2;
   localparam logic [2:0]  MIX_LIM_11K = 3'h2;
   localparam logic [2:0]  MIX_LIM_12K = 3'h2;
   localparam logic [2:0]  MIX_LIM_OTH = 3'h4;
   // ******************************************
   // types
   // ******************************************
   typedef enum logic [3:0] {CMD_NONE = 4'h0, CMD_ERR_RD = 4'h1, CMD_STAT_RD = 4'h2, CMD_VER_RD = 4'h3,
                             CMD_MUTE_REL = 4'h4, CMD_SAI_CH = 4'h5, CMD_POWER_DOWN_CMD = 4'h6} fdm_cmd_t;
   typedef enum logic [1:0] {GRP_8K = 2'h0, GRP_11K = 2'h1, GRP_12K = 2'h2, GRP_OTH = 2'h3} fdm_grp_t;
   typedef enum logic [1:0] {LR_RUN = 2'h0, LR_HALT = 2'h1, LR_UNMUTED = 2'h2} fdm_lr_t;
endpackage
`default_nettype wire

// [fdm_guard.sv]
// Functional notes
// R1: no high-quality algorithm at 8k group with serial input
// R2: mix only channels of selected group
// R3: limit mixed channels, flag mixing-count error; the code limits and flags only while the serial audio input is enabled
// R4: host starts analog power-up within 10ms
// R5: host reinitialises after memory error
// R6: resonator stop: RC after 500us, flag error
// R7: error read during switch holds busy low
// R8: host waits for busy high before reading
// R9: host stops playback on oscillator error
// R10: word clock fault keeps playback stopped
// R11: host restores clock, mute release, channel command
// R12: output on, input off disables serial input
// R13: host clears input fault enable
// R14: host lowers volume when clipping expected
// R15: read data refreshed only by read command
// R16: fault flags stay until read or reset; the code also clears them on the power-down command
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`default_nettype none
module fdm_guard
   import fdm_pkg::*;
#(
   parameter int unsigned OSC_CYC = OSC_SW_CYC
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        xtalRunPin,
   input  wire logic        wordClkPin,
   input  wire logic        audioInFaultPin,
   input  wire logic        memFaultPin,
   output logic             commandBusyN,
   output logic [NCH-1:0]   chanPlay,
   output logic             rcOscActive,
   output logic             irq
);
   // ******************************************
   // functions and pin synchronisers
   // ******************************************
   function automatic logic addrOk(input logic [7:0] a);
      addrOk = (a[1:0] == 2'h0) && (a <= ADDR_IRQ_MSK);
   endfunction
   function automatic logic [2:0] mixLimit(input fdm_grp_t g);
      case (g)
         GRP_8K:  mixLimit = MIX_LIM_8K;
         GRP_11K: mixLimit = MIX_LIM_11K;
         GRP_12K: mixLimit = MIX_LIM_12K;
         default: mixLimit = MIX_LIM_OTH;
      endcase
   endfunction
   function automatic logic [15:0] byteMerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      byteMerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction
   function automatic logic [2:0] popCount(input logic [NCH-1:0] v);
      popCount = 3'h0;
      for (int k = 0; k < NCH; k++) begin
         popCount = popCount + {2'h0, v[k]};
      end
   endfunction
   logic [1:0] xtalS, wclkS, sdiS, memS;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xtalS <= 2'h3;
         wclkS <= 2'h0;
         sdiS  <= 2'h0;
         memS  <= 2'h0;
      end else begin
         xtalS <= {xtalS[0], xtalRunPin};
         wclkS <= {wclkS[0], wordClkPin};
         sdiS  <= {sdiS[0], audioInFaultPin};
         memS  <= {memS[0], memFaultPin};
      end
   end
   // ******************************************
   // state and bus handshake
   // ******************************************
   logic [7:0]     ctrl_r, ctrl_nxt;
   logic [15:0]    chan_r, chan_nxt;
   logic [5:0]     errLive_r, errLive_nxt, errSnap_r, errSnap_nxt;
   logic [5:0]     irqSts_r, irqSts_nxt, irqMsk_r, irqMsk_nxt;
   logic [7:0]     statSnap_r, statSnap_nxt, verSnap_r, verSnap_nxt;
   logic [15:0]    oscCnt_r, oscCnt_nxt;
   logic [11:0]    lrCnt_r, lrCnt_nxt;
   logic           wclkD_r, rcAct_r, rcAct_nxt, rdErrPend_r, rdErrPend_nxt;
   logic [NCH-1:0] phrase_cmd_a_r, phrase_cmd_a_nxt;
   fdm_lr_t        lr_r, lr_nxt;
   logic           bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, irq_r, irq_nxt;
   logic [1:0]     bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]    rdata_r, rdata_nxt;
   logic           wFire, rFire, saiIn, saiUsed, switching, errTake, lrValid;
   logic           oscEvt, lrEvt, sdiEvt, memEvt, mixEvt, algoEvt;
   logic [5:0]     evt;
   logic [2:0]     nMix, lim;
   fdm_cmd_t       cmd;
   fdm_grp_t       grpSel, cg;
   assign wFire   = awvalid && wvalid && !bvalid_r;
   assign awready = wFire;
   assign wready  = wFire;
   assign rFire   = arvalid && !rvalid_r;
   assign arready = rFire;
   assign cmd     = (wFire && awaddr == ADDR_CMD && wstrb[0]) ? fdm_cmd_t'(wdata[3:0]) : CMD_NONE;
   assign saiIn     = ctrl_r[CTRL_AUDIO_INPUT_ENABLE];
   assign saiUsed   = ctrl_r[CTRL_AUDIO_OUTPUT_ENABLE] || ctrl_r[CTRL_AUDIO_INPUT_ENABLE];
   assign grpSel    = fdm_grp_t'(ctrl_r[CTRL_GRP +: 2]);
   assign switching = !xtalS[1] && !rcAct_r;
   assign lrValid   = lrCnt_r < LR_TMO_CYC[11:0];
   assign errTake   = (cmd == CMD_ERR_RD || rdErrPend_r) && !switching;
   // ******************************************
   // next-state logic
   // ******************************************
   always_comb begin
      cg = GRP_8K;
      nMix = 3'h0;
      lim = mixLimit(grpSel);
      phrase_cmd_a_nxt = '0;
      mixEvt = 1'b0;
      algoEvt = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         cg = fdm_grp_t'(chan_r[4*i +: 2]);
         if (chan_r[4*i+CH_EN] && lr_r == LR_RUN) begin
            if (saiIn && cg == GRP_8K && chan_r[4*i+CH_HQ]) begin
               algoEvt = 1'b1; // R1
            end else if (cg == grpSel) begin // R2
               if (saiIn && nMix >= lim) begin
                  mixEvt = 1'b1; // R3
               end else begin
                  phrase_cmd_a_nxt[i] = 1'b1;
                  nMix = nMix + 3'h1;
               end
            end
         end
      end
      // resonator watchdog
      oscEvt = 1'b0;
      rcAct_nxt = rcAct_r;
      oscCnt_nxt = 16'h0000;
      if (switching) begin
         if (oscCnt_r >= 16'(OSC_CYC - 1)) begin
            rcAct_nxt = 1'b1; // R6
            oscEvt = 1'b1; // R6
         end else begin
            oscCnt_nxt = oscCnt_r + 16'h0001;
         end
      end
      // word clock watchdog and recovery
      lrCnt_nxt = (wclkS[1] != wclkD_r) ? 12'h000 : (lrValid ? lrCnt_r + 12'h001 : lrCnt_r);
      lrEvt = saiUsed && !lrValid && lr_r == LR_RUN;
      lr_nxt = lr_r;
      case (lr_r)
         LR_RUN: begin
            if (lrEvt) lr_nxt = LR_HALT;
         end
         LR_HALT: begin
            if (cmd == CMD_MUTE_REL && lrValid) lr_nxt = LR_UNMUTED; // R10
         end
         LR_UNMUTED: begin
            if (cmd == CMD_SAI_CH) lr_nxt = LR_RUN;
         end
         default: lr_nxt = LR_RUN;
      endcase
      sdiEvt = saiIn && ctrl_r[CTRL_FLTEN] && sdiS[1]; // R12
      memEvt = memS[1];
      evt = {algoEvt, mixEvt, sdiEvt, lrEvt, memEvt, oscEvt};
      // error flags and read snapshots
      errLive_nxt = ((errTake || cmd == CMD_POWER_DOWN_CMD) ? 6'h00 : errLive_r) | evt; // R16
      errSnap_nxt = errTake ? (errLive_r | evt) : errSnap_r; // R15
      rdErrPend_nxt = switching && (cmd == CMD_ERR_RD || rdErrPend_r); // R7
      statSnap_nxt = (cmd == CMD_STAT_RD) ? {lr_r, rcAct_r, 1'b0, phrase_cmd_a_r} : statSnap_r; // R15
      verSnap_nxt = (cmd == CMD_VER_RD) ? VER_ID : verSnap_r;
      if (cmd == CMD_POWER_DOWN_CMD) begin
         rcAct_nxt = 1'b0;
         lr_nxt = LR_RUN;
      end
      // registers written by software
      ctrl_nxt = ctrl_r;
      chan_nxt = chan_r;
      irqMsk_nxt = irqMsk_r;
      irqSts_nxt = irqSts_r | evt;
      if (wFire) begin
         case (awaddr)
            ADDR_CTRL:    ctrl_nxt = wstrb[0] ? wdata[7:0] : ctrl_r;
            ADDR_CHAN:    chan_nxt = byteMerge(chan_r, wdata, wstrb);
            ADDR_IRQ_MSK: irqMsk_nxt = wstrb[0] ? wdata[5:0] : irqMsk_r;
            ADDR_IRQ_STS: irqSts_nxt = (irqSts_r & ~(wstrb[0] ? wdata[5:0] : 6'h00)) | evt;
            default:      ctrl_nxt = ctrl_r;
         endcase
      end
      irq_nxt = |(irqSts_nxt & irqMsk_nxt);
      // bus answers
      bvalid_nxt = bvalid_r ? !bready : wFire;
      bresp_nxt = wFire ? (addrOk(awaddr) ? RESP_OK : RESP_SLVERR) : bresp_r;
      rvalid_nxt = rvalid_r ? !rready : rFire;
      rresp_nxt = rFire ? (addrOk(araddr) ? RESP_OK : RESP_SLVERR) : rresp_r;
      rdata_nxt = rdata_r;
      if (rFire) begin
         case (araddr)
            ADDR_CTRL:    rdata_nxt = {24'h000000, ctrl_r};
            ADDR_CHAN:    rdata_nxt = {16'h0000, chan_r};
            ADDR_STAT:    rdata_nxt = {24'h000000, statSnap_r};
            ADDR_ERR:     rdata_nxt = {26'h0000000, errSnap_r};
            ADDR_VER:     rdata_nxt = {24'h000000, verSnap_r};
            ADDR_IRQ_STS: rdata_nxt = {26'h0000000, irqSts_r};
            ADDR_IRQ_MSK: rdata_nxt = {26'h0000000, irqMsk_r};
            default:      rdata_nxt = 32'h00000000;
         endcase
      end
   end
   // ******************************************
   // registers
   // ******************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r      <= CTRL_RST;
         chan_r      <= CHAN_RST;
         errLive_r   <= 6'h00;
         errSnap_r   <= 6'h00;
         irqSts_r    <= 6'h00;
         irqMsk_r    <= MASK_RST;
         statSnap_r  <= 8'h00;
         verSnap_r   <= 8'h00;
         oscCnt_r    <= 16'h0000;
         lrCnt_r     <= 12'h000;
         wclkD_r     <= 1'b0;
         rcAct_r     <= 1'b0;
         rdErrPend_r <= 1'b0;
         phrase_cmd_a_r      <= '0;
         lr_r        <= LR_RUN;
         bvalid_r    <= 1'b0;
         bresp_r     <= RESP_OK;
         rvalid_r    <= 1'b0;
         rresp_r     <= RESP_OK;
         rdata_r     <= 32'h00000000;
         irq_r       <= 1'b0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         chan_r      <= chan_nxt;
         errLive_r   <= errLive_nxt;
         errSnap_r   <= errSnap_nxt;
         irqSts_r    <= irqSts_nxt;
         irqMsk_r    <= irqMsk_nxt;
         statSnap_r  <= statSnap_nxt;
         verSnap_r   <= verSnap_nxt;
         oscCnt_r    <= oscCnt_nxt;
         lrCnt_r     <= lrCnt_nxt;
         wclkD_r     <= wclkS[1];
         rcAct_r     <= rcAct_nxt;
         rdErrPend_r <= rdErrPend_nxt;
         phrase_cmd_a_r      <= phrase_cmd_a_nxt;
         lr_r        <= lr_nxt;
         bvalid_r    <= bvalid_nxt;
         bresp_r     <= bresp_nxt;
         rvalid_r    <= rvalid_nxt;
         rresp_r     <= rresp_nxt;
         rdata_r     <= rdata_nxt;
         irq_r       <= irq_nxt;
      end
   end
   assign bvalid       = bvalid_r;
   assign bresp        = bresp_r;
   assign rvalid       = rvalid_r;
   assign rresp        = rresp_r;
   assign rdata        = rdata_r;
   assign chanPlay     = phrase_cmd_a_r;
   assign rcOscActive  = rcAct_r;
   assign irq          = irq_r;
   assign commandBusyN = !rdErrPend_r; // R7
   // ******************************************
   // assertions
   // ******************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [NCH-1:0] hq8k, offGrp;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         hq8k[i] = chan_r[4*i +: 2] == GRP_8K && chan_r[4*i+CH_HQ];
         offGrp[i] = chan_r[4*i +: 2] != grpSel;
      end
   end
   sequence s_oscDue;
      switching && oscCnt_r >= 16'(OSC_CYC - 1);
   endsequence
   sequence s_errCmdInSwitch;
      (cmd == CMD_ERR_RD || !commandBusyN) && switching;
   endsequence
   property p_algo;
      saiIn |=> (phrase_cmd_a_r & $past(hq8k)) == '0;
   endproperty
   a_algo: assert property (p_algo) else $error("hq channel mixed in 8k group"); // R1
   property p_grp;
      1'b1 |=> (phrase_cmd_a_r & $past(offGrp)) == '0;
   endproperty
   a_grp: assert property (p_grp) else $error("channel of other group mixed"); // R2
   property p_mix;
      saiIn |=> popCount(phrase_cmd_a_r) <= $past(lim);
   endproperty
   a_mix: assert property (p_mix) else $error("mix limit exceeded"); // R3
   property p_osc;
      s_oscDue ##0 cmd != CMD_POWER_DOWN_CMD |=> rcAct_r && errLive_r[ERR_OSC];
   endproperty
   a_osc: assert property (p_osc) else $error("rc switch or oscillator flag missing"); // R6
   property p_busy;
      s_errCmdInSwitch |=> !commandBusyN;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not held during switch"); // R7
   property p_lrHold;
      lr_r != LR_RUN && cmd != CMD_SAI_CH && cmd != CMD_POWER_DOWN_CMD |=> lr_r != LR_RUN && phrase_cmd_a_r == '0;
   endproperty
   a_lrHold: assert property (p_lrHold) else $error("playback resumed without recovery"); // R10
   property p_sdiOff;
      ctrl_r[CTRL_AUDIO_OUTPUT_ENABLE] && !ctrl_r[CTRL_AUDIO_INPUT_ENABLE] && sdiS[1] |=> !errLive_r[ERR_SDI] || $past(errLive_r[ERR_SDI]);
   endproperty
   a_sdiOff: assert property (p_sdiOff) else $error("disabled serial input flagged"); // R12
   property p_snap;
      cmd != CMD_ERR_RD && !rdErrPend_r |=> $stable(errSnap_r);
   endproperty
   a_snap: assert property (p_snap) else $error("error data changed without read"); // R15
   property p_stick;
      !errTake && cmd != CMD_POWER_DOWN_CMD |=> (errLive_r & $past(errLive_r)) == $past(errLive_r);
   endproperty
   a_stick: assert property (p_stick) else $error("fault flag lost before read"); // R16
endmodule
`default_nettype wire

// [fdm_env_model.sv]
`default_nettype none
// ******************************************
// audio word clock source on the far side
// ******************************************
module fdm_env_model #(
   parameter int unsigned HALF = 8
) (
   input  wire logic clk,
   input  wire logic wclkOn,
   output logic      wordClkPin
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned cnt;
   initial begin
      wordClkPin = 1'b0;
      cnt = 0;
   end
   // a stopped word clock stands still at its last level, like an open pin
   always @(posedge clk) begin
      if (wclkOn) begin
         cnt <= (cnt + 1 >= HALF) ? 0 : cnt + 1;
         if (cnt + 1 >= HALF) begin
            wordClkPin <= ~wordClkPin;
         end
      end
   end
endmodule
`default_nettype wire

// [tb_fdm_guard.sv]
`default_nettype none
module tb_fdm_guard import fdm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned OSC = 20;
   logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, wclkOn;
   logic        xtalRunPin, wordClkPin, audioInFaultPin, memFaultPin;
   logic        awready, wready, bvalid, arready, rvalid, commandBusyN, rcOscActive, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb, chanPlay;
   logic [1:0]  bresp, rresp, rsp;
   int          mismatches, checked, n;
   fdm_guard #(.OSC_CYC(OSC)) fdm_guard_i (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .xtalRunPin, .wordClkPin, .audioInFaultPin, .memFaultPin, .commandBusyN, .chanPlay, .rcOscActive, .irq);
   fdm_env_model fdm_env_model_i (.clk, .wclkOn, .wordClkPin);
   initial clk = 1'b0;
   always #25 clk = ~clk;
   // ******************************************
   // bench tasks
   // ******************************************
   task automatic complete_run();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tmo(input int lim);
      if (n >= lim) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      #1;
      for (n = 0; n < 200 && !(awready && wready); n++) begin @(posedge clk); #1; end
      tmo(200);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      #1;
      for (n = 0; n < 200 && !bvalid; n++) begin @(posedge clk); #1; end
      tmo(200);
      rsp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      #1;
      for (n = 0; n < 200 && !arready; n++) begin @(posedge clk); #1; end
      tmo(200);
      @(posedge clk);
      arvalid <= 1'b0;
      #1;
      for (n = 0; n < 200 && !rvalid; n++) begin @(posedge clk); #1; end
      tmo(200);
      rv = rdata;
      rsp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask
   task automatic cmd(input fdm_cmd_t c);
      wr(ADDR_CMD, {28'h0, c});
   endtask
   task automatic errRd(input logic [31:0] exp);
      cmd(CMD_ERR_RD);
      rd(ADDR_ERR);
      chk(rv, exp);
   endtask
   task automatic pl(input logic [3:0] e);
      repeat (2) @(posedge clk);
      #1;
      chk({28'h0, chanPlay}, {28'h0, e});
   endtask
   // ******************************************
   // main sequence
   // ******************************************
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, audioInFaultPin, memFaultPin} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      xtalRunPin = 1'b1;
      wclkOn = 1'b1;
      {mismatches, checked} = '0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      chk({31'h0, commandBusyN}, 32'h1);
      rd(ADDR_CTRL);
      chk(rv, 32'h0);
      rd(ADDR_CHAN);
      chk(rv, 32'h0);
      rd(ADDR_IRQ_MSK);
      chk(rv, 32'h0);
      rd(8'h20);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h20, 32'h1);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      $display("test reset done");
      wr(ADDR_CTRL, 32'h09);
      wr(ADDR_CHAN, 32'h0989);
      pl(4'h5);
      rd(ADDR_VER);
      chk(rv, 32'h0);
      cmd(CMD_VER_RD);
      rd(ADDR_VER);
      chk(rv, {24'h0, VER_ID});
      cmd(CMD_STAT_RD);
      rd(ADDR_STAT);
      chk(rv, 32'h05);
      $display("test group done");
      wr(ADDR_CTRL, 32'h03);
      wr(ADDR_CHAN, 32'h008C);
      pl(4'h2);
      rd(ADDR_ERR);
      chk(rv, 32'h0);
      errRd(32'h20);
      wr(ADDR_IRQ_MSK, 32'h20);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_CHAN, 32'h0);
      wr(ADDR_IRQ_STS, 32'h20);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(ADDR_IRQ_STS);
      chk(rv, 32'h0);
      $display("test algorithm done");
      wr(ADDR_CHAN, 32'h0888);
      repeat (2) @(posedge clk);
      chk(32'($countones(chanPlay)), {29'h0, MIX_LIM_8K});
      errRd(32'h30);
      wr(ADDR_CTRL, 32'h1B);
      wr(ADDR_CHAN, 32'hBBBB);
      pl(4'hF);
      $display("test mixing done");
      wr(ADDR_CHAN, 32'h0);
      memFaultPin <= 1'b1;
      repeat (5) @(posedge clk);
      memFaultPin <= 1'b0;
      repeat (5) @(posedge clk);
      errRd(32'h12);
      errRd(32'h0);
      memFaultPin <= 1'b1;
      repeat (5) @(posedge clk);
      memFaultPin <= 1'b0;
      repeat (5) @(posedge clk);
      cmd(CMD_POWER_DOWN_CMD);
      errRd(32'h0);
      audioInFaultPin <= 1'b1;
      wr(ADDR_CTRL, 32'h05);
      errRd(32'h0);
      wr(ADDR_CTRL, 32'h07);
      errRd(32'h08);
      audioInFaultPin <= 1'b0;
      wr(ADDR_CTRL, 32'h01);
      errRd(32'h08);
      $display("test faults done");
      wr(ADDR_CTRL, 32'h19);
      wr(ADDR_CHAN, 32'h000B);
      pl(4'h1);
      wclkOn <= 1'b0;
      repeat (4100) @(posedge clk);
      pl(4'h0);
      errRd(32'h04);
      wclkOn <= 1'b1;
      repeat (200) @(posedge clk);
      pl(4'h0);
      cmd(CMD_MUTE_REL);
      cmd(CMD_SAI_CH);
      pl(4'h1);
      errRd(32'h0);
      $display("test word clock done");
      xtalRunPin <= 1'b0;
      repeat (3) @(posedge clk);
      cmd(CMD_ERR_RD);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, commandBusyN}, 32'h0);
      chk({31'h0, rcOscActive}, 32'h0);
      for (n = 0; n < 400 && !commandBusyN; n++) begin @(posedge clk); #1; end
      tmo(400);
      chk({31'h0, rcOscActive}, 32'h1);
      chk({31'h0, 1'(n + 8 >= OSC)}, 32'h1);
      rd(ADDR_ERR);
      chk(rv, 32'h01);
      wr(ADDR_CHAN, 32'h0);
      pl(4'h0);
      $display("test oscillator done");
      complete_run();
   end
endmodule
`default_nettype wire
